/* dpro_out_stage.sv */
// One output register stage with synchronous reset and priority choice
module dpro_out_stage (
    // Clock and reset
    input  wire logic                           sys_clk_in,
    input  wire logic                           rst_in,
    // Stage control
    input  wire logic                           enable_in,
    input  wire logic                           reset_in,
    input  wire logic                           setreset_priority_in,
    // Data
    input  wire logic [dpro_pkg::READ_WIDTH-1:0] data_in,
    output logic      [dpro_pkg::READ_WIDTH-1:0] data_out
);
    import dpro_pkg::*;

    logic [READ_WIDTH-1:0] next_data;

    always_comb begin
        next_data = data_out;
        if (reset_in && (setreset_priority_in || enable_in)) begin
            next_data = OUTPUT_RESET_VALUE;
        end else if (enable_in) begin
            next_data = data_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_out <= '0;
        end else begin
            data_out <= next_data;
        end
    end
endmodule : dpro_out_stage

/* dpro_pkg.sv */
// Shared constants and types for the configurable single RAM port
package dpro_pkg;
    // Generation limits
    localparam int WRITE_WIDTH_MIN = 1;
    localparam int WRITE_WIDTH_MAX = 4608;
    localparam int WRITE_DEPTH_MIN = 2;
    localparam int WRITE_DEPTH_MAX = 131072;
    // Generated port shape
    localparam int WRITE_WIDTH = 16;
    localparam int WRITE_DEPTH = 16;
    localparam int READ_RATIO  = 1;
    localparam int READ_WIDTH  = WRITE_WIDTH * READ_RATIO;
    localparam int READ_DEPTH  = (WRITE_DEPTH * WRITE_WIDTH) / READ_WIDTH;
    localparam int ADDR_WIDTH  = $clog2(WRITE_DEPTH);
    localparam int RADDR_WIDTH = $clog2(READ_DEPTH);
    // Reset value of output latch and registers
    localparam logic [READ_WIDTH-1:0] OUTPUT_RESET_VALUE = 16'h0000;
    // Latch-reset hold lengths in cycles
    localparam int RESET_HOLD_PLAIN = 1;
    localparam int RESET_HOLD_LATCH = 2;

    typedef enum {
        DPRO_READ_FIRST,
        DPRO_WRITE_FIRST,
        DPRO_NO_CHANGE
    } dpro_mode_type;

    typedef struct packed {
        logic                   write;
        logic [ADDR_WIDTH-1:0]  addr;
        logic [WRITE_WIDTH-1:0] data;
    } dpro_request_type;

    // Output-register option bundle
    typedef struct packed {
        logic use_enable;
        logic prim_reg;
        logic core_reg;
        logic use_regce;
        logic use_reset;
        logic setreset_priority;
        logic latch_reset;
    } dpro_options_type;
endpackage : dpro_pkg

/* dpro_port.sv */
// One configurable RAM port: array, write mode, output latch and register stages
// What this block does
// - Write width is fixed at generation, between 1 and 4608 bits.
// - Write depth is fixed at generation, between 2 and 131072 words.
// - Read width is a ratio of write width; depth keeps capacity equal.
// - Port runs read-first, write-first or no-change on writes.
// - Port is always enabled or gated by its access enable input.
// - Optional primitive output register adds one cycle of read latency.
// - Optional core output register adds another cycle of latency.
// - Output clock enable alone gates last stage; else access enable gates all.
// - Without the output reset input, latch and registers reset only on rst_in.
// - With reset input, clock enable or set/reset may take priority.
// - Latch-reset option needs reset input, primitive register, no core register.
// - Latch-reset changes reset duration; driver holds reset long enough.
// - Output reset loads a constant sized to the read width.
module dpro_port #(
    parameter dpro_pkg::dpro_mode_type MODE      = dpro_pkg::DPRO_WRITE_FIRST,
    parameter bit                      USE_EN    = 1'b1,
    parameter bit                      PRIM_REG  = 1'b0,
    parameter bit                      CORE_REG  = 1'b0,
    parameter bit                      USE_REGCE = 1'b0,
    parameter bit                      USE_RST   = 1'b0,
    parameter bit                      SETRESET_PRIO = 1'b0,
    parameter bit                      LATCH_RST = 1'b0
) (
    // Clock and reset
    input  wire logic                            sys_clk_in,
    input  wire logic                            rst_in,
    // Port control
    input  wire logic                            port_a_access_enable_in,
    input  wire logic                            port_a_outreg_clock_enable_in,
    input  wire logic                            port_a_output_reset_in,
    // Request
    input  wire dpro_pkg::dpro_request_type      request_in,
    // Read data and status
    output logic      [dpro_pkg::READ_WIDTH-1:0] read_data_out,
    output logic      [1:0]                      read_latency_out,
    output logic      [1:0]                      reset_hold_cycles_out,
    output dpro_pkg::dpro_options_type           options_out
);
    import dpro_pkg::*;

    // Generation-time checks of width, depth and ratio
    if (WRITE_WIDTH < WRITE_WIDTH_MIN || WRITE_WIDTH > WRITE_WIDTH_MAX) begin : g_bad_width
        $error("write width out of range");
    end
    if (WRITE_DEPTH < WRITE_DEPTH_MIN || WRITE_DEPTH > WRITE_DEPTH_MAX) begin : g_bad_depth
        $error("write depth out of range");
    end
    if (READ_DEPTH * READ_WIDTH != WRITE_DEPTH * WRITE_WIDTH) begin : g_bad_ratio
        $error("read and write capacity differ");
    end
    // Latch reset only legal with reset pin, primitive register, no core register
    localparam bit LATCH_OK = LATCH_RST && USE_RST && PRIM_REG && !CORE_REG;

    // Array held as read-width words; one write word fills one of them at its address
    logic [READ_WIDTH-1:0] mem [READ_DEPTH];

    logic                  en;
    logic                  rst_req;
    logic                  wr;
    logic [READ_WIDTH-1:0] old_word;
    logic [READ_WIDTH-1:0] latch;
    logic [READ_WIDTH-1:0] next_latch;
    logic [READ_WIDTH-1:0] prim_q;
    logic [READ_WIDTH-1:0] core_q;
    logic                  prim_en;
    logic                  core_en;
    logic                  latch_rst;

    assign en       = USE_EN ? port_a_access_enable_in : 1'b1;
    assign rst_req  = USE_RST ? port_a_output_reset_in : 1'b0;
    assign wr       = en && request_in.write;
    assign old_word = mem[RADDR_WIDTH'(request_in.addr)];

    // Array write
    always_ff @(posedge sys_clk_in) begin
        if (wr) begin
            mem[RADDR_WIDTH'(request_in.addr)] <= request_in.data;
        end
    end

    // Latch reset: with latch reset the latch clears too, so reset value
    // lasts one more cycle through the register stage
    assign latch_rst = USE_RST && (!PRIM_REG || LATCH_OK) && rst_req
                       && (SETRESET_PRIO || en);

    always_comb begin
        next_latch = latch;
        if (latch_rst) begin
            next_latch = OUTPUT_RESET_VALUE;
        end else if (en) begin
            unique case (MODE)
                DPRO_READ_FIRST:  next_latch = old_word;
                DPRO_WRITE_FIRST: next_latch = wr ? request_in.data : old_word;
                DPRO_NO_CHANGE:   next_latch = wr ? latch : old_word;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            latch <= '0;
        end else begin
            latch <= next_latch;
        end
    end

    // Last stage uses the output clock enable when configured
    assign prim_en = (USE_REGCE && !CORE_REG) ? port_a_outreg_clock_enable_in : en;
    assign core_en = USE_REGCE ? port_a_outreg_clock_enable_in : en;

    dpro_out_stage u_prim_stage (
        .sys_clk_in           (sys_clk_in),
        .rst_in               (rst_in),
        .enable_in            (prim_en),
        .reset_in             (rst_req),
        .setreset_priority_in (SETRESET_PRIO),
        .data_in              (latch),
        .data_out             (prim_q)
    );

    dpro_out_stage u_core_stage (
        .sys_clk_in           (sys_clk_in),
        .rst_in               (rst_in),
        .enable_in            (core_en),
        .reset_in             (rst_req),
        .setreset_priority_in (SETRESET_PRIO),
        .data_in              (PRIM_REG ? prim_q : latch),
        .data_out             (core_q)
    );

    always_comb begin
        if (CORE_REG) begin
            read_data_out = core_q;
        end else if (PRIM_REG) begin
            read_data_out = prim_q;
        end else begin
            read_data_out = latch;
        end
    end

    assign read_latency_out      = 2'(1 + int'(PRIM_REG) + int'(CORE_REG));
    assign reset_hold_cycles_out = LATCH_OK ? 2'(RESET_HOLD_LATCH)
                                            : 2'(RESET_HOLD_PLAIN);
    assign options_out = '{use_enable:        USE_EN,
                           prim_reg:          PRIM_REG,
                           core_reg:          CORE_REG,
                           use_regce:         USE_REGCE,
                           use_reset:         USE_RST,
                           setreset_priority: SETRESET_PRIO,
                           latch_reset:       LATCH_OK};
endmodule : dpro_port

/* dpro_sva.sv */
// Concurrent checks on one configured RAM port
module dpro_sva #(
    parameter bit PRIM_REG  = 1'b1,
    parameter bit CORE_REG  = 1'b0,
    parameter bit USE_RST   = 1'b1,
    parameter bit LATCH_RST = 1'b1
) (
    // Watched ports
    input wire logic                            sys_clk_in,
    input wire logic                            rst_in,
    input wire logic                            port_a_access_enable_in,
    input wire logic                            port_a_output_reset_in,
    input wire dpro_pkg::dpro_request_type      request_in,
    input wire logic [dpro_pkg::READ_WIDTH-1:0] read_data_out,
    input wire logic [1:0]                      read_latency_out,
    input wire logic [1:0]                      reset_hold_cycles_out,
    input wire dpro_pkg::dpro_options_type      options_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import dpro_pkg::*;
    localparam bit LOK = USE_RST && PRIM_REG && !CORE_REG && LATCH_RST;
    wire en   = port_a_access_enable_in;
    wire orst = port_a_output_reset_in;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_write; en && request_in.write && !orst; endsequence
    sequence s_step; en && !orst; endsequence
    a_latency_fixed: assert property (read_latency_out == 2'(1 + PRIM_REG + CORE_REG))
        else $error("read latency wrong");
    a_hold_length: assert property (reset_hold_cycles_out == (LOK ? 2'd2 : 2'd1))
        else $error("reset hold length wrong");
    a_latch_legal: assert property (options_out.latch_reset == LOK)
        else $error("latch reset option wrong");
    a_option_copy: assert property (options_out.core_reg == CORE_REG)
        else $error("core register option wrong");
    a_idle_hold: assert property (!en |=> $stable(read_data_out))
        else $error("output moved while disabled");
    a_write_through: assert property (
        s_write ##1 s_step |=> read_data_out == $past(request_in.data, 2))
        else $error("write did not pass new data");
    a_reset_value: assert property ((en && orst)[*2] |=> read_data_out == OUTPUT_RESET_VALUE)
        else $error("output reset value wrong");
    a_async_clear: assert property ($fell(rst_in) |-> read_data_out == OUTPUT_RESET_VALUE)
        else $error("output not cleared by reset");
endmodule : dpro_sva

bind dpro_port dpro_sva #(
    .PRIM_REG(PRIM_REG), .CORE_REG(CORE_REG), .USE_RST(USE_RST), .LATCH_RST(LATCH_RST)
) u_sva (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .request_in(request_in),
    .port_a_access_enable_in(port_a_access_enable_in),
    .port_a_output_reset_in(port_a_output_reset_in), .read_data_out(read_data_out),
    .read_latency_out(read_latency_out), .reset_hold_cycles_out(reset_hold_cycles_out),
    .options_out(options_out)
);

/* dpro_user.sv */
// User logic model that drives requests into the RAM port
module dpro_user (
    // Clock
    input  wire logic                  sys_clk_in,
    // Requests
    output dpro_pkg::dpro_request_type request_out,
    output logic                       enable_out,
    output logic                       reset_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import dpro_pkg::*;
    initial begin
        request_out = '0;
        enable_out  = 1'b0;
        reset_out   = 1'b0;
    end
    // Idle cycles carry flipped data so stale values never pass for live ones
    task automatic drive(input logic en, input logic rst, input dpro_request_type req);
        @(posedge sys_clk_in);
        #1;
        enable_out  = en;
        reset_out   = rst;
        request_out = en ? req : ~request_out;
    endtask : drive
endmodule : dpro_user

/* testbench.sv */
// Self-checking bench for one RAM port in write-first mode
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dpro_pkg::*;
    logic                  sys_clk_in;
    logic                  rst_in;
    logic                  en;
    logic                  orst;
    dpro_request_type      req;
    logic [READ_WIDTH-1:0] rdata;
    logic [READ_WIDTH-1:0] mem [WRITE_DEPTH];
    logic [READ_WIDTH-1:0] q [$];
    logic [31:0]           seed = 32'h105cbfed;
    localparam dpro_request_type READ3 = '{1'b0, 4'h3, 16'h0000};
    int                    err_total = 0;
    int                    checks = 0;
    dpro_port #(.PRIM_REG(1'b1), .USE_RST(1'b1), .LATCH_RST(1'b1)) DUT (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .port_a_access_enable_in(en),
        .port_a_outreg_clock_enable_in(~en), .port_a_output_reset_in(orst),
        .request_in(req), .read_data_out(rdata), .read_latency_out(),
        .reset_hold_cycles_out(), .options_out()
    );
    dpro_user DRV (.sys_clk_in(sys_clk_in), .request_out(req), .enable_out(en), .reset_out(orst));
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Write-first: a write returns its own data
    function automatic logic [READ_WIDTH-1:0] expect_word(input dpro_request_type r);
        if (r.write) mem[r.addr] = r.data;
        return mem[r.addr];
    endfunction : expect_word
    task automatic chk(input logic [READ_WIDTH-1:0] seen, input logic [READ_WIDTH-1:0] want);
        checks++;
        if (seen !== want) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : chk
    task automatic op(input logic e, input logic r, input dpro_request_type rq);
        DRV.drive(e, r, rq);
        if (q.size() == 2) chk(rdata, q[0]);
        if (r) q.delete();
        else if (e) q.push_back(expect_word(rq));
        if (q.size() > 2) void'(q.pop_front());
    endtask : op
    task automatic test_done();
        if (err_total == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    initial begin
        #20us;
        err_total++;
        test_done();
    end
    initial begin
        rst_in = 1'b1;
        repeat (4) @(posedge sys_clk_in);
        #1 rst_in = 1'b0;
        chk(rdata, OUTPUT_RESET_VALUE);
        for (int a = 0; a < WRITE_DEPTH; a++) op(1'b1, 1'b0, '{1'b1, 4'(a), 16'(a * 16'h1111)});
        repeat (2) op(1'b1, 1'b0, READ3);
        // Enable priority: reset with enable low must not touch the output
        repeat (2) op(1'b0, 1'b1, READ3);
        chk(rdata, mem[3]);
        repeat (2) op(1'b1, 1'b1, READ3);
        op(1'b1, 1'b0, READ3);
        chk(rdata, OUTPUT_RESET_VALUE);
        // Cleared latch keeps the reset value on the output one cycle longer
        op(1'b1, 1'b0, READ3);
        chk(rdata, OUTPUT_RESET_VALUE);
        repeat (400) begin
            seed = lfsr(seed);
            op(seed[8] | seed[9], 1'b0, dpro_request_type'(seed[20:0]));
        end
        test_done();
    end
endmodule : testbench
